// ===== logic/dmaar_pkg.sv
// constants and types for the dma alias and irq register bank
package dmaar_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CH   = 12;
  localparam int IRQ_W    = 16;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int CH_IDX_W = 4;

  // ==========================================================================
  // per-channel alias offsets, channel 0; channel n adds n * stride
  localparam logic [11:0] CH_STRIDE            = 12'h040;
  localparam logic [5:0]  OFS_AL1_CTRL         = 6'h10;
  localparam logic [5:0]  OFS_AL1_SRC_PTR      = 6'h14;
  localparam logic [5:0]  OFS_AL1_DEST_PTR     = 6'h18;
  localparam logic [5:0]  OFS_AL1_COUNT_TRIG   = 6'h1c;
  localparam logic [5:0]  OFS_AL2_CTRL         = 6'h20;
  localparam logic [5:0]  OFS_AL2_COUNT        = 6'h24;
  localparam logic [5:0]  OFS_AL2_SRC_PTR      = 6'h28;
  localparam logic [5:0]  OFS_AL2_DEST_TRIG    = 6'h2c;
  localparam logic [5:0]  OFS_AL3_CTRL         = 6'h30;
  localparam logic [5:0]  OFS_AL3_DEST_PTR     = 6'h34;
  localparam logic [5:0]  OFS_AL3_COUNT        = 6'h38;
  localparam logic [5:0]  OFS_AL3_SRC_TRIG     = 6'h3c;
  localparam logic [3:0]  TRIG_WORD            = 4'hc;

  // ==========================================================================
  // interrupt registers
  localparam logic [11:0] OFS_RAW_IRQ_PENDING  = 12'h400;
  localparam logic [11:0] OFS_IRQ0_ENABLE_MASK = 12'h404;
  localparam logic [11:0] OFS_IRQ0_FORCE_MASK  = 12'h408;
  localparam logic [11:0] OFS_IRQ0_MASKED      = 12'h40c;
  localparam logic [11:0] OFS_IRQ1_ENABLE_MASK = 12'h414;
  localparam logic [11:0] OFS_IRQ1_FORCE_MASK  = 12'h418;
  localparam logic [11:0] OFS_IRQ1_MASKED      = 12'h41c;

  // ==========================================================================
  // reset values and fields
  localparam logic [15:0] IRQ_RESET  = 16'h0000;
  localparam logic [31:0] CH_RESET   = 32'h0000_0000;
  localparam int          CTRL_EN_BIT = 0;

  typedef enum logic [2:0] {
    FLD_NONE,
    FLD_CTRL,
    FLD_SRC,
    FLD_DEST,
    FLD_COUNT
  } dmaar_field_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmaar_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] src_ptr;
    logic [DATA_W-1:0] dest_ptr;
    logic [DATA_W-1:0] transfer_count;
  } dmaar_chan_t;

endpackage

// ===== logic/dmaar_regs.sv
// register bank: channel alias sets and channel interrupt aggregation
`timescale 1ns/1ps

module dmaar_regs
(
  // clock, reset, enable
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          ce_i,
  // register port
  input  wire dmaar_pkg::dmaar_req_t         reg_req_i,
  output logic [dmaar_pkg::DATA_W-1:0]       reg_rdata_o,
  // channel engine side
  input  wire logic [dmaar_pkg::NUM_CH-1:0]  ch_busy_i,
  input  wire logic [dmaar_pkg::IRQ_W-1:0]   ch_irq_i,
  output dmaar_pkg::dmaar_chan_t             ch_regs_o [dmaar_pkg::NUM_CH],
  output logic [dmaar_pkg::NUM_CH-1:0]       ch_start_o,
  // system interrupts
  output logic                               irq0_o,
  output logic                               irq1_o
);

  // ==========================================================================
  // alias decode
  function automatic dmaar_pkg::dmaar_field_t field_of
  (
    input logic [5:0] ofs
  );
    dmaar_pkg::dmaar_field_t f;
    f = dmaar_pkg::FLD_NONE;
    case (ofs)
      dmaar_pkg::OFS_AL1_CTRL:       f = dmaar_pkg::FLD_CTRL;
      dmaar_pkg::OFS_AL1_SRC_PTR:    f = dmaar_pkg::FLD_SRC;
      dmaar_pkg::OFS_AL1_DEST_PTR:   f = dmaar_pkg::FLD_DEST;
      dmaar_pkg::OFS_AL1_COUNT_TRIG: f = dmaar_pkg::FLD_COUNT;
      dmaar_pkg::OFS_AL2_CTRL:       f = dmaar_pkg::FLD_CTRL;
      dmaar_pkg::OFS_AL2_COUNT:      f = dmaar_pkg::FLD_COUNT;
      dmaar_pkg::OFS_AL2_SRC_PTR:    f = dmaar_pkg::FLD_SRC;
      dmaar_pkg::OFS_AL2_DEST_TRIG:  f = dmaar_pkg::FLD_DEST;
      dmaar_pkg::OFS_AL3_CTRL:       f = dmaar_pkg::FLD_CTRL;
      dmaar_pkg::OFS_AL3_DEST_PTR:   f = dmaar_pkg::FLD_DEST;
      dmaar_pkg::OFS_AL3_COUNT:      f = dmaar_pkg::FLD_COUNT;
      dmaar_pkg::OFS_AL3_SRC_TRIG:   f = dmaar_pkg::FLD_SRC;
      default:                       f = dmaar_pkg::FLD_NONE;
    endcase
    return f;
  endfunction

  // picks one of the four channel words
  function automatic logic [31:0] field_word
  (
    input dmaar_pkg::dmaar_chan_t  c,
    input dmaar_pkg::dmaar_field_t f
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (f)
      dmaar_pkg::FLD_CTRL:  w = c.ctrl;
      dmaar_pkg::FLD_SRC:   w = c.src_ptr;
      dmaar_pkg::FLD_DEST:  w = c.dest_ptr;
      dmaar_pkg::FLD_COUNT: w = c.transfer_count;
      default:              w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ==========================================================================
  // state
  dmaar_pkg::dmaar_chan_t          chan_q [dmaar_pkg::NUM_CH];
  logic [dmaar_pkg::IRQ_W-1:0]     pending_q;
  logic [dmaar_pkg::IRQ_W-1:0]     pending_d;
  logic [dmaar_pkg::IRQ_W-1:0]     en0_q;
  logic [dmaar_pkg::IRQ_W-1:0]     force0_q;
  logic [dmaar_pkg::IRQ_W-1:0]     en1_q;
  logic [dmaar_pkg::IRQ_W-1:0]     force1_q;
  logic [dmaar_pkg::NUM_CH-1:0]    start_q;
  logic [dmaar_pkg::NUM_CH-1:0]    start_d;
  logic [dmaar_pkg::DATA_W-1:0]    rdata_q;
  logic [dmaar_pkg::DATA_W-1:0]    rdata_d;

  // ==========================================================================
  // address and write decode
  logic [dmaar_pkg::CH_IDX_W-1:0]  ch_idx_w;
  dmaar_pkg::dmaar_field_t         fld_w;
  logic                            chan_ok_w;
  logic                            trig_slot_w;
  logic                            trig_fire_w;
  logic                            wr_raw_w;
  logic                            wr_en0_w;
  logic                            wr_f0_w;
  logic                            wr_ms0_w;
  logic                            wr_en1_w;
  logic                            wr_f1_w;
  logic                            wr_ms1_w;
  logic [dmaar_pkg::IRQ_W-1:0]     wmask_w;
  logic [dmaar_pkg::IRQ_W-1:0]     clr_w;
  logic [dmaar_pkg::IRQ_W-1:0]     masked0_w;
  logic [dmaar_pkg::IRQ_W-1:0]     masked1_w;
  logic [dmaar_pkg::DATA_W-1:0]    rd_word_w;

  assign ch_idx_w    = reg_req_i.addr[9:6];
  assign fld_w       = field_of(reg_req_i.addr[5:0]);
  // channel window sits below 0x400; channels past the last read as unmapped
  assign chan_ok_w   = (reg_req_i.addr[11:10] == 2'b00)
                     && (ch_idx_w < 4'(dmaar_pkg::NUM_CH))
                     && (fld_w != dmaar_pkg::FLD_NONE);
  assign trig_slot_w = chan_ok_w
                     && (reg_req_i.addr[3:0] == dmaar_pkg::TRIG_WORD);
  // a zero write to a trigger word is a plain store
  assign trig_fire_w = reg_req_i.we && trig_slot_w
                     && (reg_req_i.wdata != 32'h0000_0000);

  assign wmask_w  = reg_req_i.wdata[dmaar_pkg::IRQ_W-1:0];
  assign wr_raw_w = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_RAW_IRQ_PENDING);
  assign wr_en0_w = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ0_ENABLE_MASK);
  assign wr_f0_w  = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ0_FORCE_MASK);
  assign wr_ms0_w = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ0_MASKED);
  assign wr_en1_w = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ1_ENABLE_MASK);
  assign wr_f1_w  = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ1_FORCE_MASK);
  assign wr_ms1_w = reg_req_i.we
                  && (reg_req_i.addr == dmaar_pkg::OFS_IRQ1_MASKED);

  // any of the three status words clears by mask
  assign clr_w = (wr_raw_w || wr_ms0_w || wr_ms1_w) ? wmask_w
               : dmaar_pkg::IRQ_RESET;
  // new events win over a clear in the same cycle
  assign pending_d = (pending_q & ~clr_w) | ch_irq_i;

  // ==========================================================================
  // interrupt outputs
  assign masked0_w = (pending_q | force0_q) & en0_q;
  assign masked1_w = (pending_q | force1_q) & en1_q;
  assign irq0_o    = |masked0_w;
  assign irq1_o    = |masked1_w;

  // ==========================================================================
  // start decision: only an enabled and idle channel may start
  always_comb
  begin
    start_d = '0;
    for (int n = 0; n < dmaar_pkg::NUM_CH; n++)
    begin
      start_d[n] = trig_fire_w && (ch_idx_w == 4'(n))
                 && chan_q[n].ctrl[dmaar_pkg::CTRL_EN_BIT]
                 && !ch_busy_i[n];
    end
  end

  // ==========================================================================
  // read path
  always_comb
  begin
    rd_word_w = 32'h0000_0000;
    if (chan_ok_w)
    begin
      rd_word_w = field_word(chan_q[ch_idx_w], fld_w);
    end
    else
    begin
      case (reg_req_i.addr)
        dmaar_pkg::OFS_RAW_IRQ_PENDING:  rd_word_w = {16'h0000, pending_q};
        dmaar_pkg::OFS_IRQ0_ENABLE_MASK: rd_word_w = {16'h0000, en0_q};
        dmaar_pkg::OFS_IRQ0_FORCE_MASK:  rd_word_w = {16'h0000, force0_q};
        dmaar_pkg::OFS_IRQ0_MASKED:      rd_word_w = {16'h0000, masked0_w};
        dmaar_pkg::OFS_IRQ1_ENABLE_MASK: rd_word_w = {16'h0000, en1_q};
        dmaar_pkg::OFS_IRQ1_FORCE_MASK:  rd_word_w = {16'h0000, force1_q};
        dmaar_pkg::OFS_IRQ1_MASKED:      rd_word_w = {16'h0000, masked1_w};
        default:                         rd_word_w = 32'h0000_0000;
      endcase
    end
  end

  // read data stands for exactly one ce_i-enabled cycle after the strobe
  assign rdata_d = reg_req_i.re ? rd_word_w : 32'h0000_0000;

  // ==========================================================================
  // channel words; every alias of a field writes the same storage
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      for (int n = 0; n < dmaar_pkg::NUM_CH; n++)
      begin
        chan_q[n] <= '{dmaar_pkg::CH_RESET, dmaar_pkg::CH_RESET,
                       dmaar_pkg::CH_RESET, dmaar_pkg::CH_RESET};
      end
    end
    else if (ce_i && reg_req_i.we && chan_ok_w)
    begin
      case (fld_w)
        dmaar_pkg::FLD_CTRL:  chan_q[ch_idx_w].ctrl     <= reg_req_i.wdata;
        dmaar_pkg::FLD_SRC:   chan_q[ch_idx_w].src_ptr  <= reg_req_i.wdata;
        dmaar_pkg::FLD_DEST:  chan_q[ch_idx_w].dest_ptr <= reg_req_i.wdata;
        dmaar_pkg::FLD_COUNT:
          chan_q[ch_idx_w].transfer_count <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // interrupt registers, start pulses, read data
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      pending_q <= dmaar_pkg::IRQ_RESET;
      en0_q     <= dmaar_pkg::IRQ_RESET;
      force0_q  <= dmaar_pkg::IRQ_RESET;
      en1_q     <= dmaar_pkg::IRQ_RESET;
      force1_q  <= dmaar_pkg::IRQ_RESET;
      start_q   <= '0;
      rdata_q   <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pending_q <= pending_d;
      en0_q     <= wr_en0_w ? wmask_w : en0_q;
      force0_q  <= wr_f0_w  ? wmask_w : force0_q;
      en1_q     <= wr_en1_w ? wmask_w : en1_q;
      force1_q  <= wr_f1_w  ? wmask_w : force1_q;
      start_q   <= start_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign ch_start_o  = start_q;
  assign ch_regs_o   = chan_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  a_trig_starts_idle: assert property (
    ce_i && trig_fire_w && chan_q[ch_idx_w].ctrl[dmaar_pkg::CTRL_EN_BIT]
    && !ch_busy_i[ch_idx_w]
    |=> ch_start_o[$past(ch_idx_w)] && $onehot(ch_start_o))
    else $error("nonzero trigger on idle enabled channel did not start");

  a_zero_no_start: assert property (
    ce_i && reg_req_i.we && trig_slot_w
    && (reg_req_i.wdata == 32'h0000_0000)
    |=> (ch_start_o == '0)
        && (field_word(chan_q[$past(ch_idx_w)], $past(fld_w))
            == 32'h0000_0000))
    else $error("zero trigger write started a channel or was lost");

  a_busy_blocks: assert property (
    ce_i && trig_fire_w
    && (ch_busy_i[ch_idx_w]
        || !chan_q[ch_idx_w].ctrl[dmaar_pkg::CTRL_EN_BIT])
    |=> ch_start_o == '0)
    else $error("busy or disabled channel was started");

  a_alias_store: assert property (
    ce_i && reg_req_i.we && chan_ok_w
    |=> field_word(chan_q[$past(ch_idx_w)], $past(fld_w))
        == $past(reg_req_i.wdata))
    else $error("alias write did not reach the channel word");

  a_alias_read: assert property (
    ce_i && reg_req_i.re && chan_ok_w && !reg_req_i.we
    |=> reg_rdata_o == field_word(chan_q[$past(ch_idx_w)], $past(fld_w)))
    else $error("alias read returned wrong channel word");

  a_event_wins: assert property (
    ce_i && (ch_irq_i != '0)
    |=> (pending_q & $past(ch_irq_i)) == $past(ch_irq_i))
    else $error("channel event lost against a clear");

  a_mask_clears: assert property (
    ce_i && (wr_raw_w || wr_ms0_w || wr_ms1_w) && (ch_irq_i == '0)
    |=> pending_q == ($past(pending_q) & ~$past(wmask_w)))
    else $error("status mask write did not clear pending flags");

  // without a mask write on this edge, force and enable hold one more cycle;
  // a later write may legally drop the force, so only two cycles are claimed
  a_force_holds: assert property (
    ce_i && (force0_q & en0_q) != '0 && !wr_f0_w && !wr_en0_w
    |-> irq0_o [*2])
    else $error("forced irq0 dropped while force bit still set");

  a_irq0_read: assert property (
    ce_i && reg_req_i.re && (reg_req_i.addr == dmaar_pkg::OFS_IRQ0_MASKED)
    |=> (reg_rdata_o[15:0] != 16'h0000) == $past(irq0_o))
    else $error("masked status disagrees with irq0");

  a_upper_zero: assert property (
    ce_i && reg_req_i.re && !chan_ok_w
    |=> reg_rdata_o[31:16] == 16'h0000)
    else $error("reserved upper status bits read nonzero");

  a_irq_isolated: assert property (
    (en0_q == '0) && (force0_q == '0) |-> !irq0_o)
    else $error("irq0 asserted with no enabled source");

  // ==========================================================================
  // start, force, storage, reset and freeze checks
  // a start pulse may only follow a nonzero trigger write
  a_start_needs_trig: assert property (
    ce_i && !trig_fire_w |=> ch_start_o == '0)
    else $error("start pulse without a nonzero trigger write");

  a_irq1_forced: assert property (
    (force1_q & en1_q) != '0 |-> irq1_o)
    else $error("enabled irq1 force bit did not raise irq1");

  a_enable_store: assert property (
    ce_i && wr_en0_w
    |=> en0_q == $past(reg_req_i.wdata[15:0]))
    else $error("irq0 enable mask write not stored");

  a_force_store: assert property (
    ce_i && wr_f0_w
    |=> force0_q == $past(reg_req_i.wdata[15:0]))
    else $error("irq0 force mask write not stored");

  // clearing pending flags must never touch the force bits
  a_clear_keeps_force: assert property (
    ce_i && (wr_raw_w || wr_ms0_w || wr_ms1_w)
    |=> force0_q == $past(force0_q) && force1_q == $past(force1_q))
    else $error("status clear changed a force mask");

  a_reset_clean: assert property (
    $rose(rst_b_i)
    |-> (en0_q == '0) && (force0_q == '0) && (pending_q == '0)
        && (ch_start_o == '0) && !irq0_o && !irq1_o)
    else $error("register bank not clean after reset");

  // a low enable must hold the irq flops, read data and start pulses
  a_enable_freezes: assert property (
    !ce_i
    |=> $stable(pending_q) && $stable(en0_q) && $stable(force0_q)
        && $stable(en1_q) && $stable(force1_q)
        && $stable(reg_rdata_o) && $stable(ch_start_o))
    else $error("state changed while the clock enable was low");

  c_trig_start: cover property (ce_i && trig_fire_w ##1 ch_start_o != '0);
  c_busy_refuse: cover property (ce_i && trig_fire_w && ch_busy_i != '0);
  c_set_clear: cover property (ce_i && wr_raw_w && (ch_irq_i & wmask_w) != '0);
  c_both_irqs: cover property (irq0_o && irq1_o);
  c_irq1_force: cover property (ce_i && (force1_q & en1_q) != '0);

endmodule // dmaar_regs

// ===== sim/dmaar_regs_tb.sv
// self-checking testbench for the dma alias and irq register bank
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
  end

module dmaar_regs_tb;

  // ==========================================================================
  // stimulus and observed signals
  localparam logic [11:0] RAW  = dmaar_pkg::OFS_RAW_IRQ_PENDING;
  localparam logic [11:0] EN0  = dmaar_pkg::OFS_IRQ0_ENABLE_MASK;
  localparam logic [11:0] FRC0 = dmaar_pkg::OFS_IRQ0_FORCE_MASK;
  localparam logic [11:0] MSK0 = dmaar_pkg::OFS_IRQ0_MASKED;
  localparam logic [11:0] EN1  = dmaar_pkg::OFS_IRQ1_ENABLE_MASK;
  localparam logic [11:0] FRC1 = dmaar_pkg::OFS_IRQ1_FORCE_MASK;
  localparam logic [11:0] MSK1 = dmaar_pkg::OFS_IRQ1_MASKED;

  logic                         clk_sys_i = 1'b0;
  logic                         rst_b_i   = 1'b0;
  logic                         ce_i      = 1'b1;
  dmaar_pkg::dmaar_req_t        req       = '0;
  logic [11:0]                  busy      = '0;
  logic [15:0]                  irq_ev    = '0;
  logic [31:0]                  rdata;
  dmaar_pkg::dmaar_chan_t       regs [dmaar_pkg::NUM_CH];
  logic [11:0]                  start;
  logic [11:0]                  start_seen;
  logic                         irq0;
  logic                         irq1;
  int                           err_total = 0;
  int                           checked   = 0;
  int                           chs [3]   = '{0, 5, 11};
  logic [5:0]                   trg [3];
  logic [5:0]                   mir [3];
  logic [31:0]                  cv;
  logic [11:0]                  ch_bit;

  always #2 clk_sys_i = ~clk_sys_i;

  dmaar_regs DUT (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .reg_req_i   (req),
    .reg_rdata_o (rdata),
    .ch_busy_i   (busy),
    .ch_irq_i    (irq_ev),
    .ch_regs_o   (regs),
    .ch_start_o  (start),
    .irq0_o      (irq0),
    .irq1_o      (irq1)
  );

  // ==========================================================================
  // bus tasks
  function automatic logic [11:0] ca(input int ch, input logic [5:0] ofs);
    return 12'(ch) * dmaar_pkg::CH_STRIDE + {6'h00, ofs};
  endfunction

  // start pulse is captured in the cycle after the write edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req.we    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk_sys_i);
    req.we    <= 1'b0;
    #1;
    start_seen = start;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    req.re   <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys_i);
    req.re   <= 1'b0;
    #1;
    `CHK(rdata, exp);
  endtask

  task automatic set_busy(input logic [11:0] v);
    @(posedge clk_sys_i);
    busy <= v;
  endtask

  task automatic pulse_irq(input logic [15:0] v);
    @(posedge clk_sys_i);
    irq_ev <= v;
    @(posedge clk_sys_i);
    irq_ev <= '0;
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    trg = '{dmaar_pkg::OFS_AL1_COUNT_TRIG, dmaar_pkg::OFS_AL2_DEST_TRIG,
            dmaar_pkg::OFS_AL3_SRC_TRIG};
    mir = '{dmaar_pkg::OFS_AL2_COUNT, dmaar_pkg::OFS_AL3_DEST_PTR,
            dmaar_pkg::OFS_AL2_SRC_PTR};
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd_chk(RAW, 32'h0000_0000);
    rd_chk(EN0, 32'h0000_0000);
    rd_chk(FRC0, 32'h0000_0000);
    rd_chk(MSK0, 32'h0000_0000);
    rd_chk(12'h300, 32'h0000_0000);
    // first, middle and last channel, written through alias set 2, the destination pointer through alias set 1
    for (int i = 0; i < 3; i++)
    begin
      cv = 32'(chs[i]);
      wr(ca(chs[i], dmaar_pkg::OFS_AL2_CTRL), 32'h5a00_0000 + (cv << 4));
      wr(ca(chs[i], dmaar_pkg::OFS_AL2_COUNT), 32'h0000_1000 + cv);
      wr(ca(chs[i], dmaar_pkg::OFS_AL2_SRC_PTR), 32'h2000_0000 + cv);
      wr(ca(chs[i], dmaar_pkg::OFS_AL1_DEST_PTR), 32'h3000_0000 + cv);
      `CHK(start_seen, 12'h000);
      rd_chk(ca(chs[i], dmaar_pkg::OFS_AL3_CTRL),
             32'h5a00_0000 + (cv << 4));
      rd_chk(ca(chs[i], dmaar_pkg::OFS_AL3_DEST_PTR),
             32'h3000_0000 + cv);
      rd_chk(ca(chs[i], dmaar_pkg::OFS_AL3_COUNT),
             32'h0000_1000 + cv);
      rd_chk(ca(chs[i], dmaar_pkg::OFS_AL1_SRC_PTR),
             32'h2000_0000 + cv);
      rd_chk(ca(chs[i], dmaar_pkg::OFS_AL2_DEST_TRIG),
             32'h3000_0000 + cv);
      `CHK(regs[chs[i]].transfer_count, 32'h0000_1000 + cv);
    end
    // each trigger word: busy, zero, good, then disabled channel
    for (int t = 0; t < 3; t++)
    begin
      ch_bit = 12'h001 << (2 + t);
      wr(ca(2 + t, dmaar_pkg::OFS_AL2_CTRL), 32'h0000_0001);
      set_busy(ch_bit);
      wr(ca(2 + t, trg[t]), 32'h0000_0011);
      `CHK(start_seen, 12'h000);
      set_busy(12'h000);
      wr(ca(2 + t, trg[t]), 32'h0000_0000);
      `CHK(start_seen, 12'h000);
      rd_chk(ca(2 + t, mir[t]), 32'h0000_0000);
      wr(ca(2 + t, trg[t]), 32'h0000_0040 + 32'(t));
      `CHK(start_seen, ch_bit);
      @(posedge clk_sys_i);
      #1;
      `CHK(start, 12'h000);
      rd_chk(ca(2 + t, mir[t]),
             32'h0000_0040 + 32'(t));
      wr(ca(2 + t, dmaar_pkg::OFS_AL3_CTRL), 32'h0000_0000);
      wr(ca(2 + t, trg[t]), 32'h0000_0077);
      `CHK(start_seen, 12'h000);
    end
    // pending, enables on both irq lines, clear through masked status for irq0 and raw for irq1
    pulse_irq(16'h8008);
    rd_chk(RAW, 32'h0000_8008);
    `CHK(irq0, 1'b0);
    wr(EN0, 32'hffff_0008);
    rd_chk(EN0, 32'h0000_0008);
    `CHK(irq0, 1'b1);
    rd_chk(MSK0, 32'h0000_0008);
    `CHK(irq1, 1'b0);
    wr(EN1, 32'h0000_8000);
    `CHK(irq1, 1'b1);
    wr(MSK0, 32'h0000_0008);
    rd_chk(RAW, 32'h0000_8000);
    `CHK(irq0, 1'b0);
    wr(RAW, 32'h0000_8000);
    rd_chk(RAW, 32'h0000_0000);
    `CHK(irq1, 1'b0);
    // force holds irq0 even when the pending flag is cleared
    wr(FRC0, 32'hffff_0004);
    rd_chk(FRC0, 32'h0000_0004);
    `CHK(irq0, 1'b0);
    wr(EN0, 32'h0000_000c);
    `CHK(irq0, 1'b1);
    rd_chk(MSK0, 32'h0000_0004);
    rd_chk(RAW, 32'h0000_0000);
    wr(RAW, 32'h0000_0004);
    `CHK(irq0, 1'b1);
    wr(FRC0, 32'h0000_0000);
    `CHK(irq0, 1'b0);
    // irq1 side: masked status, clear through it, then force
    pulse_irq(16'h8001);
    `CHK(irq1, 1'b1);
    `CHK(irq0, 1'b0);
    rd_chk(MSK1, 32'h0000_8000);
    wr(MSK1, 32'h0000_8000);
    rd_chk(RAW, 32'h0000_0001);
    `CHK(irq1, 1'b0);
    wr(FRC1, 32'h0000_0002);
    wr(EN1, 32'h0000_0002);
    `CHK(irq1, 1'b1);
    rd_chk(MSK1, 32'h0000_0002);
    // an event and a clear of the same flag in one cycle: the event wins
    @(posedge clk_sys_i);
    irq_ev    <= 16'h0001;
    req.we    <= 1'b1;
    req.addr  <= RAW;
    req.wdata <= 32'h0000_0001;
    @(posedge clk_sys_i);
    irq_ev <= '0;
    req.we <= 1'b0;
    rd_chk(RAW, 32'h0000_0001);
    // a low enable freezes writes, events and outputs alike
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(FRC1, 32'h0000_0000);
    `CHK(irq1, 1'b1);
    wr(ca(0, dmaar_pkg::OFS_AL2_CTRL), 32'h0000_0001);
    pulse_irq(16'h0002);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rd_chk(ca(0, dmaar_pkg::OFS_AL2_CTRL), 32'h5a00_0000);
    rd_chk(RAW, 32'h0000_0001);
    wr(FRC1, 32'h0000_0000);
    `CHK(irq1, 1'b0);
    end_sim();
  end

  // ==========================================================================
  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    #80_000;
    err_total++;
    end_sim();
  end

endmodule // dmaar_regs_tb
